// File: inc/bsw_beat_if.sv
`timescale 1ns/1ps
interface bsw_beat_if;
    import bsw_pkg::*;
    logic wrEn;
    logic [BSW_ADDR_W-1:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrLanes;
    logic [BSW_ADDR_W-1:0] rdAddr;
    logic [31:0] rdData;
    modport owner (output wrEn, output wrAddr, output wrData, output wrLanes,
        output rdAddr, input rdData);
    modport store (input wrEn, input wrAddr, input wrData, input wrLanes,
        input rdAddr, output rdData);
endinterface : bsw_beat_if

// File: inc/bsw_pkg.sv
package bsw_pkg;
    localparam int BSW_ADDR_W = 32;
    localparam int BSW_LEN_W = 8;
    localparam logic [1:0] BSW_PCYC_CLKS = 2'h2;
    localparam logic [3:0] BSW_BLOCK_BYTES = 4'hf;
    localparam logic [2:0] BSW_SCALE_LO = 3'h2;
    localparam logic [2:0] BSW_SCALE_HI = 3'h4;
    localparam logic [4:0] BSW_BASE_FRAME = 5'h0f;
    localparam logic [4:0] BSW_BASE_MREG = 5'h03;
    localparam logic [4:0] BSW_BASE_MLONG = 5'h06;
    localparam logic [4:0] BSW_BASE_EXTP = 5'h04;
    typedef enum logic [1:0] {
        BSW_OP_FRAME_ENTRY,
        BSW_OP_MULTI_REGISTER_STORE,
        BSW_OP_MULTI_LONGWORD_STORE,
        BSW_OP_EXTENDED_PROCESSOR_TRANSFER
    } bsw_op_t;
    typedef enum logic [1:0] {
        BSW_KIND_HEAD,
        BSW_KIND_BODY,
        BSW_KIND_TAIL
    } bsw_kind_t;
endpackage : bsw_pkg

// File: sim/bsw_mem_model.sv
`timescale 1ns/1ps
module bsw_mem_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic busReq,
    input wire logic [bsw_pkg::BSW_ADDR_W-1:0] busAddr,
    input wire logic [31:0] busData,
    input wire logic [3:0] busLanes,
    input wire logic wide32,
    input wire logic [3:0] waitClks,
    input wire logic noBurst,
    output logic memAck,
    output logic memBurstStop
);
    import bsw_pkg::*;
    logic [7:0] mem [0:63];
    logic [3:0] waitCnt;
    // refusal held as a level so every beat sees it
    assign memBurstStop = noBurst;
    // ack after the wait, one cycle only; only selected lanes change
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            memAck <= 1'b0;
            waitCnt <= 4'h0;
            foreach (mem[i]) mem[i] <= 8'h00;
        end else if (memAck) begin
            memAck <= 1'b0;
            waitCnt <= 4'h0;
        end else if (busReq && waitCnt >= waitClks) begin
            memAck <= 1'b1;
            for (int i = 0; i < 4; i++) begin
                // a narrow memory has two lanes on the addressed halfword
                if (busLanes[i]) begin
                    mem[wide32 ? {busAddr[5:2], 2'(i)}
                        : {busAddr[5:1], 1'(i)}] <= busData[8*i +: 8];
                end
            end
        end else if (busReq) begin
            waitCnt <= waitCnt + 4'h1;
        end
    end
endmodule : bsw_mem_model

// File: sim/bsw_seq_props.sv
`timescale 1ns/1ps
module bsw_seq_props (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic wide32,
    input wire logic startValid,
    input wire logic [bsw_pkg::BSW_LEN_W-1:0] startLen,
    input wire logic memAck,
    input wire logic memBurstStop,
    input wire logic startReady,
    input wire logic busReq,
    input wire logic busBurst,
    input wire logic busLast,
    input wire logic [bsw_pkg::BSW_ADDR_W-1:0] busAddr,
    input wire logic [3:0] busLanes,
    input wire bsw_pkg::bsw_kind_t busKind,
    input wire logic doneValid
);
    import bsw_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // a beat only hangs off a started store
    idle_no_beat_a: assert property (startReady |-> !busReq)
        else $error("beat while idle");
    beat_hold_a: assert property
        (busReq && !memAck |=> busReq && $stable(busAddr) && $stable(busLanes))
        else $error("beat changed before ack");
    start_beat_a: assert property
        (startValid && startReady && startLen != 0 && clkEn |-> ##3 busReq)
        else $error("no beat after start");
    // bursts carry whole units and never open a new block
    burst_unit_a: assert property
        (busReq && busBurst |-> (wide32 ? busLanes == 4'hf : busLanes inside {4'h3, 4'hc}))
        else $error("burst beat not a full unit");
    block_edge_a: assert property (busReq && busBurst |-> busAddr[3:0] != 4'h0)
        else $error("burst crossed block");
    burst_refuse_a: assert property
        ($rose(busReq) && $past(memBurstStop) |-> busLast && !busBurst)
        else $error("burst after refusal");
    single_lanes_a: assert property
        (busReq && busKind != BSW_KIND_BODY |-> !busBurst && $countones(busLanes) inside {1, 2})
        else $error("head or tail lanes wrong");
    done_pulse_a: assert property (doneValid |-> $past(memAck) ##1 !doneValid)
        else $error("done not a pulse after ack");
endmodule : bsw_seq_props
bind bsw_write_seq bsw_seq_props u_bsw_seq_props (.core_clk, .sys_rst, .clkEn, .wide32,
    .startValid, .startLen, .memAck, .memBurstStop, .startReady, .busReq, .busBurst,
    .busLast, .busAddr, .busLanes, .busKind, .doneValid);

// File: sim/burst_store_write_sequencer_test.sv
`timescale 1ns/1ps
`define BSW_CHECK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module burst_store_write_sequencer_test;
    import bsw_pkg::*;
    logic core_clk = 0, sys_rst = 1, clkEn = 1, wide32 = 1, scale4 = 0, noBurst = 0;
    logic loadValid = 0, startValid = 0, memAck, memBurstStop, startReady, busReq;
    logic busBurst, busLast, busClk, doneValid;
    logic [7:0] loadByte = 8'h00;
    logic [3:0] waitClks = 4'h0, busLanes;
    bsw_op_t startOp = BSW_OP_FRAME_ENTRY;
    bsw_kind_t busKind;
    logic [31:0] startAddr = 32'h0, busAddr, busData;
    logic [7:0] startLen = 8'h00;
    logic [15:0] doneCycles;
    logic [4:0] bases [4] = '{BSW_BASE_FRAME, BSW_BASE_MREG, BSW_BASE_MLONG, BSW_BASE_EXTP};
    int miscompares = 0, num_checks = 0, acks = 0, bursts = 0, lasts = 0;
    initial forever #5 core_clk = ~core_clk;
    bsw_write_seq u_bsw_write_seq (.core_clk, .sys_rst, .clkEn, .wide32, .scale4,
        .loadValid, .loadByte, .startValid, .startOp, .startAddr, .startLen, .memAck,
        .memBurstStop, .startReady, .busReq, .busBurst, .busLast, .busAddr, .busData,
        .busLanes, .busKind, .busClk, .doneValid, .doneCycles);
    bsw_mem_model u_bsw_mem_model (.core_clk, .sys_rst, .busReq, .busAddr, .busData,
        .busLanes, .wide32, .waitClks, .noBurst, .memAck, .memBurstStop);
    // tally accepted beats and how many of them were burst continuations
    always @(posedge core_clk) begin
        if (busReq && memAck) begin
            acks++;
            if (busBurst) bursts++;
            if (busLast) lasts++;
        end
    end
    task automatic report_and_stop();
        if (miscompares == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    // fresh reset each store so untouched bytes read back zero
    task automatic store_case(input bsw_op_t op, input int addr, input int len,
        input int expAcks, input int expBursts);
        int n;
        sys_rst = 1;
        repeat (2) @(posedge core_clk);
        #1 sys_rst = 0;
        for (int i = 0; i < len; i++) begin
            loadValid = 1;
            loadByte = 8'(i + 8'ha1);
            @(posedge core_clk);
            #1;
        end
        loadValid = 0;
        startValid = 1;
        startOp = op;
        startAddr = 32'(addr);
        startLen = 8'(len);
        acks = 0;
        bursts = 0;
        lasts = 0;
        n = 0;
        while (doneValid !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            #1;
            n++;
            // a second start while busy must be ignored
            startValid = (n == 2);
            startAddr = 32'h32;
        end
        if (n == 400) begin
            miscompares++;
            report_and_stop();
        end
        `BSW_CHECK(doneCycles, 16'(expAcks) + 16'(bases[op]))
        `BSW_CHECK(acks, expAcks)
        `BSW_CHECK(bursts, expBursts)
        `BSW_CHECK(lasts, expAcks - expBursts)
        `BSW_CHECK(startReady, 1'b0)
        for (int i = 0; i < len; i++) begin
            `BSW_CHECK(u_bsw_mem_model.mem[addr + i], 8'(i + 8'ha1))
        end
        `BSW_CHECK(u_bsw_mem_model.mem[addr - 1], 8'h00)
        `BSW_CHECK(u_bsw_mem_model.mem[addr + len], 8'h00)
        `BSW_CHECK(u_bsw_mem_model.mem[50], 8'h00)
        // done is a one-cycle pulse; the sequencer reopens after its gap
        repeat (2) @(posedge core_clk);
        #1;
        `BSW_CHECK(doneValid, 1'b0)
        `BSW_CHECK(startReady, 1'b1)
    endtask : store_case
    // bus clock period from a clean reset, then held while the clock enable is low
    task automatic bus_clock_case(input logic s4);
        int n;
        int rise0;
        int period;
        logic prev;
        logic held;
        sys_rst = 1;
        scale4 = s4;
        repeat (2) @(posedge core_clk);
        #1 sys_rst = 0;
        prev = busClk;
        rise0 = -1;
        n = 0;
        while (n < 40) begin
            @(posedge core_clk);
            #1;
            n++;
            if (busClk && !prev) begin
                if (rise0 >= 0) break;
                rise0 = n;
            end
            prev = busClk;
        end
        period = int'(BSW_PCYC_CLKS) * int'(s4 ? BSW_SCALE_HI : BSW_SCALE_LO);
        `BSW_CHECK(n - rise0, period)
        clkEn = 0;
        held = busClk;
        repeat (6) @(posedge core_clk);
        #1;
        `BSW_CHECK(busClk, held)
        clkEn = 1;
    endtask : bus_clock_case
    // head byte, head word, one single longword
    task automatic walk_case();
        store_case(BSW_OP_FRAME_ENTRY, 13, 7, 3, 0);
    endtask : walk_case
    // seven longwords at 13 for every store kind, zero to three wait clocks, both scales
    task automatic all_ops_case();
        for (int k = 0; k < 4; k++) begin
            {scale4, waitClks} = {k[0], 4'(k)};
            store_case(bsw_op_t'(k), 13, 28, 9, 4);
        end
    endtask : all_ops_case
    // narrow memory: block edge splits the burst, byte head
    task automatic narrow_case();
        {wide32, scale4, waitClks} = {1'b0, 1'b0, 4'h1};
        store_case(BSW_OP_MULTI_REGISTER_STORE, 1, 5, 3, 1);
        store_case(BSW_OP_MULTI_LONGWORD_STORE, 12, 8, 4, 2);
        wide32 = 1;
    endtask : narrow_case
    // refused bursts and a three byte tail
    task automatic refuse_tail_case();
        noBurst = 1;
        store_case(BSW_OP_EXTENDED_PROCESSOR_TRANSFER, 13, 28, 9, 0);
        noBurst = 0;
        store_case(BSW_OP_MULTI_REGISTER_STORE, 16, 7, 3, 0);
    endtask : refuse_tail_case
    initial begin
        walk_case();
        all_ops_case();
        narrow_case();
        refuse_tail_case();
        bus_clock_case(1'b0);
        bus_clock_case(1'b1);
        report_and_stop();
    end
endmodule : burst_store_write_sequencer_test

// File: src/bsw_data_mem.sv
`timescale 1ns/1ps
module bsw_data_mem #(
    parameter int DEPTH = 64
) (
    input wire logic core_clk,
    input wire logic clkEn,
    bsw_beat_if.store port
);
    import bsw_pkg::*;
    localparam int AW = $clog2(DEPTH);
    logic [7:0] mem [0:DEPTH-1];
    logic [31:0] rdData_reg;
    initial begin
        if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("bsw_data_mem: DEPTH must be a power of two of at least 4");
        end
    end
    // byte-wide staging store for the operand bytes of one instruction
    always_ff @(posedge core_clk) begin
        if (clkEn) begin
            for (int i = 0; i < 4; i++) begin
                if (port.wrEn && port.wrLanes[i]) begin
                    mem[AW'(port.wrAddr + BSW_ADDR_W'(i))] <= port.wrData[8*i +: 8];
                end
            end
        end
    end
    // registered read of four consecutive bytes, no reset needed on data
    always_ff @(posedge core_clk) begin
        if (clkEn) begin
            for (int i = 0; i < 4; i++) begin
                rdData_reg[8*i +: 8] <= mem[AW'(port.rdAddr + BSW_ADDR_W'(i))];
            end
        end
    end
    assign port.rdData = rdData_reg;
endmodule : bsw_data_mem

// File: src/bsw_write_seq.sv
`timescale 1ns/1ps
// How it works
// - multi-operand stores try burst writes
// - unaligned start: one or two head writes
// - first aligned unit single, then burst onward
// - burst ends: done, short, block edge, refused
// - short remainder goes as tail writes
// - unaligned word/longword adds extra writes
// - cycle count is references plus base
// - one processor cycle is two clocks
// - bus scale factor two or four
// - one pending write; later store stalls
module bsw_write_seq #(
    parameter int DEPTH = 64
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic wide32,
    input wire logic scale4,
    input wire logic loadValid,
    input wire logic [7:0] loadByte,
    input wire logic startValid,
    input wire bsw_pkg::bsw_op_t startOp,
    input wire logic [bsw_pkg::BSW_ADDR_W-1:0] startAddr,
    input wire logic [bsw_pkg::BSW_LEN_W-1:0] startLen,
    input wire logic memAck,
    input wire logic memBurstStop,
    output logic startReady,
    output logic busReq,
    output logic busBurst,
    output logic busLast,
    output logic [bsw_pkg::BSW_ADDR_W-1:0] busAddr,
    output logic [31:0] busData,
    output logic [3:0] busLanes,
    output bsw_pkg::bsw_kind_t busKind,
    output logic busClk,
    output logic doneValid,
    output logic [15:0] doneCycles
);
    import bsw_pkg::*;
    typedef enum logic [2:0] {S_IDLE, S_FETCH, S_ISSUE, S_WAIT, S_GAP} bsw_state_t;
    bsw_beat_if beat();
    bsw_state_t state_reg;
    bsw_op_t op_reg;
    logic [BSW_ADDR_W-1:0] addr_reg;
    logic [BSW_LEN_W-1:0] left_reg, loadIdx_reg, len_reg;
    logic inBurst_reg;
    logic [15:0] refs_reg;
    logic pcPhase_reg;
    logic [1:0] busDiv_reg;
    logic [2:0] gap_reg;
    logic [1:0] width, mis;
    logic [2:0] unit, chunk, room;
    logic [3:0] lanes;
    logic aligned, canBurst;
    logic [4:0] base;
    initial begin
        if (DEPTH < 4 || DEPTH > (1 << BSW_LEN_W)) begin
            $error("bsw_write_seq: DEPTH out of range");
        end
    end
    bsw_data_mem #(.DEPTH(DEPTH)) u_mem (.core_clk(core_clk), .clkEn(clkEn), .port(beat));
    // staging writes come from the load port, reads follow the bus pointer
    assign beat.wrEn = loadValid && (state_reg == S_IDLE);
    assign beat.wrAddr = BSW_ADDR_W'(loadIdx_reg);
    assign beat.wrData = {24'h000000, loadByte};
    assign beat.wrLanes = 4'h1;
    // latched length: the start inputs may move while a store is running
    assign beat.rdAddr = BSW_ADDR_W'(len_reg - left_reg);
    // width of the current single or burst unit
    always_comb begin
        unit = wide32 ? 3'h4 : 3'h2;
        width = wide32 ? 2'h3 : 2'h1;
        mis = addr_reg[1:0] & width;
        aligned = (mis == 2'h0);
        room = 3'(unit - 3'(mis));
        // head: largest piece that is naturally placed and stays below alignment
        if (!aligned) begin
            // never wider than what is left, so a short remainder keeps its lanes
            chunk = (mis[0] || room == 3'h1 || left_reg < BSW_LEN_W'(2)) ? 3'h1 : 3'h2;
        end else if (left_reg >= BSW_LEN_W'(unit)) begin
            chunk = unit;
        end else begin
            chunk = (left_reg >= BSW_LEN_W'(2) && !addr_reg[0]) ? 3'h2 : 3'h1;
        end
        // lanes cover only the bytes in this write
        case (chunk)
            3'h1: lanes = 4'h1;
            3'h2: lanes = 4'h3;
            default: lanes = 4'hf;
        endcase
        lanes = wide32 ? 4'(lanes << addr_reg[1:0]) : 4'(lanes << addr_reg[0]);
        // burst continues on aligned full units inside one block
        canBurst = aligned && left_reg >= BSW_LEN_W'(2 * unit)
            && ((addr_reg[3:0] + 4'(unit)) != 4'h0) && !memBurstStop;
        case (op_reg)
            BSW_OP_FRAME_ENTRY: base = BSW_BASE_FRAME;
            BSW_OP_MULTI_REGISTER_STORE: base = BSW_BASE_MREG;
            BSW_OP_MULTI_LONGWORD_STORE: base = BSW_BASE_MLONG;
            default: base = BSW_BASE_EXTP;
        endcase
    end
    // processor cycle phase: two clocks per processor cycle
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pcPhase_reg <= 1'b0;
        end else if (clkEn) begin
            pcPhase_reg <= pcPhase_reg + 1'b1;
        end
    end
    // bus clock divided from the processor cycle by 2 or 4
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busDiv_reg <= 2'h0;
            busClk <= 1'b0;
        end else if (clkEn && pcPhase_reg) begin
            busDiv_reg <= busDiv_reg + 2'h1;
            busClk <= scale4 ? busDiv_reg[1] : busDiv_reg[0];
        end
    end
    // operand byte loading while idle
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            loadIdx_reg <= '0;
        end else if (clkEn) begin
            if (state_reg == S_IDLE && startValid && startReady) begin
                loadIdx_reg <= '0;
            end else if (beat.wrEn) begin
                loadIdx_reg <= loadIdx_reg + BSW_LEN_W'(1);
            end
        end
    end
    // sequencer: head, burst body, tail, one write outstanding
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= S_IDLE;
            op_reg <= BSW_OP_FRAME_ENTRY;
            addr_reg <= '0;
            left_reg <= '0;
            len_reg <= '0;
            inBurst_reg <= 1'b0;
            refs_reg <= '0;
            gap_reg <= '0;
            startReady <= 1'b1;
            busReq <= 1'b0;
            busBurst <= 1'b0;
            busLast <= 1'b0;
            busAddr <= '0;
            busData <= '0;
            busLanes <= '0;
            busKind <= BSW_KIND_HEAD;
            doneValid <= 1'b0;
            doneCycles <= '0;
        end else if (clkEn) begin
            doneValid <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    // store runs in the background, the core keeps executing
                    if (startValid && startLen != '0) begin
                        op_reg <= startOp;
                        addr_reg <= startAddr;
                        left_reg <= startLen;
                        len_reg <= startLen;
                        inBurst_reg <= 1'b0;
                        refs_reg <= '0;
                        startReady <= 1'b0; // a later store stalls here
                        state_reg <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    state_reg <= S_ISSUE; // read data lands one clock later
                end
                S_ISSUE: begin
                    busReq <= 1'b1;
                    busAddr <= addr_reg;
                    busLanes <= lanes;
                    busData <= 32'(beat.rdData << (8 * (wide32 ? addr_reg[1:0]
                        : {1'b0, addr_reg[0]})));
                    // a short unaligned remainder is still the tail, not a head
                    busKind <= (chunk == unit) ? BSW_KIND_BODY
                        : ((aligned || left_reg < BSW_LEN_W'(unit)) ? BSW_KIND_TAIL
                        : BSW_KIND_HEAD);
                    busBurst <= inBurst_reg && !memBurstStop;
                    busLast <= canBurst ? 1'b0 : 1'b1;
                    inBurst_reg <= canBurst && chunk == unit;
                    addr_reg <= addr_reg + BSW_ADDR_W'(chunk);
                    left_reg <= left_reg - BSW_LEN_W'(chunk);
                    state_reg <= S_WAIT;
                end
                S_WAIT: begin
                    if (memAck) begin
                        busReq <= 1'b0;
                        // a burst beat costs one bus clock, single writes one
                        refs_reg <= refs_reg + 16'h1;
                        if (left_reg == '0) begin
                            doneValid <= 1'b1;
                            doneCycles <= 16'(refs_reg + 16'h1 + 16'(base));
                            // one idle processor cycle before the next store
                            gap_reg <= 3'(BSW_PCYC_CLKS);
                            state_reg <= S_GAP;
                        end else if (inBurst_reg) begin
                            state_reg <= S_FETCH;
                        end else begin
                            // single writes separated by half scale of gap
                            gap_reg <= scale4 ? BSW_SCALE_LO : 3'h1;
                            state_reg <= S_GAP;
                        end
                    end
                end
                S_GAP: begin
                    if (gap_reg <= 3'h1) begin
                        if (left_reg == '0) begin
                            startReady <= 1'b1;
                            state_reg <= S_IDLE;
                        end else begin
                            state_reg <= S_FETCH;
                        end
                    end else begin
                        gap_reg <= gap_reg - 3'h1;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule : bsw_write_seq
